// ===== src/rkbc_reset_ctrl.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rkbc_reset_ctrl
(
    // Clock and power-on reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Shared pin and system
    input  wire logic       pin_level,
    input  wire logic       pin_alt_select,
    input  wire logic       low_supply,
    input  wire logic       sleep_or_idle,
    input  wire logic       watchdog_key_fault,
    input  wire logic       watchdog_warm_reset,
    // Outputs
    output logic            pin_is_reset,
    output logic            pin_alt_enable,
    output logic            brownout_monitor_en,
    output logic      [2:0] brownout_threshold_sel,
    output logic            system_reset
);
    typedef enum logic [1:0]
    {
        RKBC_RUN,
        RKBC_PULSE,
        RKBC_HOLD
    } rkbc_state_t;

    logic [7:0]  pin_function_key;
    logic [7:0]  brownout_threshold_key;
    logic [3:0]  reset_cause_flags;
    logic [7:0]  next_pin_function_key;
    logic [7:0]  next_brownout_threshold_key;
    logic [3:0]  next_reset_cause_flags;
    logic [7:0]  next_reg_rdata;
    rkbc_state_t state;
    rkbc_state_t next_state;
    logic [2:0]  pulse_count;
    logic [2:0]  next_pulse_count;
    logic        next_system_reset;
    logic        next_pin_is_reset;
    logic        next_pin_alt_enable;
    logic        next_bo_en;
    logic [2:0]  next_bo_sel;
    logic        pin_key_bad;
    logic        bo_key_bad;
    logic        bo_enabled;
    logic        bo_low;
    logic        pin_low;
    logic        pin_fault_done;
    logic        bo_fault_done;
    logic        bo_qual_done;
    logic        warm;
    logic        restore_keys;
    rkbc_pkg::rkbc_bo_sel_t bo_sel;

    assign pin_key_bad = (pin_function_key != rkbc_pkg::PIN_KEY_IO)
                      && (pin_function_key != rkbc_pkg::PIN_KEY_RESET);

    always_comb
    begin
        bo_key_bad = 1'b0;
        bo_sel     = rkbc_pkg::BO_SEL_OFF;
        case (brownout_threshold_key)
            rkbc_pkg::BO_CODE_1V70: bo_sel = rkbc_pkg::BO_SEL_1V70;
            rkbc_pkg::BO_CODE_1V90: bo_sel = rkbc_pkg::BO_SEL_1V90;
            rkbc_pkg::BO_CODE_2V55: bo_sel = rkbc_pkg::BO_SEL_2V55;
            rkbc_pkg::BO_CODE_3V15: bo_sel = rkbc_pkg::BO_SEL_3V15;
            rkbc_pkg::BO_CODE_3V80: bo_sel = rkbc_pkg::BO_SEL_3V80;
            rkbc_pkg::BO_CODE_OFF:  bo_sel = rkbc_pkg::BO_SEL_OFF;
            default:                bo_key_bad = 1'b1;
        endcase
    end

    // monitor gated in sleep and idle
    assign bo_enabled = !bo_key_bad && (bo_sel != rkbc_pkg::BO_SEL_OFF)
                     && !sleep_or_idle;
    assign bo_low  = bo_enabled && low_supply && (state == RKBC_RUN);
    // low pin counts only when reset role chosen
    assign pin_low = (pin_function_key == rkbc_pkg::PIN_KEY_RESET)
                  && !pin_level;

    rkbc_delay u_pin_fault
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (pin_key_bad && state == RKBC_RUN),
        .limit   (rkbc_pkg::CNT_W'(rkbc_pkg::SW_FAULT_CYCLES)),
        .done    (pin_fault_done)
    );

    rkbc_delay u_bo_fault
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (bo_key_bad && state == RKBC_RUN),
        .limit   (rkbc_pkg::CNT_W'(rkbc_pkg::SW_FAULT_CYCLES)),
        .done    (bo_fault_done)
    );

    rkbc_delay u_bo_qual
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (bo_low),
        .limit   (rkbc_pkg::CNT_W'(rkbc_pkg::BO_QUALIFY_CYCLES)),
        .done    (bo_qual_done)
    );

    // release delay counted in hold state
    // Pin key is restored on entry, so the raw level
    // is watched here; a long low keeps the reset held
    logic rel_done;
    rkbc_delay u_release
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .run     (state == RKBC_HOLD && pin_level),
        .limit   (rkbc_pkg::CNT_W'(rkbc_pkg::PIN_RELEASE_CYCLES)),
        .done    (rel_done)
    );

    // Reset sequencing
    always_comb
    begin
        next_state       = state;
        next_pulse_count = pulse_count;
        warm             = 1'b0;
        restore_keys     = 1'b0;
        case (state)
            RKBC_RUN:
            begin
                next_pulse_count = '0;
                if (pin_low)
                begin
                    next_state   = RKBC_HOLD;
                    restore_keys = 1'b1;
                end
                else if (pin_fault_done || bo_fault_done || bo_qual_done
                         || watchdog_key_fault)
                begin
                    next_state   = RKBC_PULSE;
                    restore_keys = 1'b1;
                end
                else if (watchdog_warm_reset)
                begin
                    // warm reset keeps the pin key
                    next_state = RKBC_PULSE;
                    warm       = 1'b1;
                end
            end
            RKBC_PULSE:
            begin
                next_pulse_count = 3'(pulse_count + 1'b1);
                if (pulse_count == 3'(rkbc_pkg::RESET_PULSE_CYCLES - 1))
                    next_state = RKBC_RUN;
            end
            RKBC_HOLD:
            begin
                if (rel_done)
                    next_state = RKBC_RUN;
            end
            default:
                next_state = RKBC_RUN;
        endcase
        next_system_reset = (next_state != RKBC_RUN);
    end

    // Register writes and flag updates
    always_comb
    begin
        next_pin_function_key       = pin_function_key;
        next_brownout_threshold_key = brownout_threshold_key;
        next_reset_cause_flags      = reset_cause_flags;
        if (reg_write && reg_addr == rkbc_pkg::ADDR_PIN_KEY)
            next_pin_function_key = reg_wdata;
        if (reg_write && reg_addr == rkbc_pkg::ADDR_BO_KEY)
            next_brownout_threshold_key = reg_wdata;
        // software write is the only clear apart from the reset input
        // brownout key flag same clear path
        if (reg_write && reg_addr == rkbc_pkg::ADDR_FLAGS)
            next_reset_cause_flags = reset_cause_flags & reg_wdata[3:0];
        // restore pin key on non-warm reset
        if (restore_keys)
            next_pin_function_key = rkbc_pkg::PIN_KEY_RST;
        // brownout key returns to default on non-warm reset unless a brownout caused it
        if (restore_keys && !bo_qual_done)
            next_brownout_threshold_key = rkbc_pkg::BO_KEY_RST;
        if (restore_keys && bo_qual_done && !bo_fault_done)
            next_brownout_threshold_key = brownout_threshold_key;
        // Set wins over a simultaneous clear
        if (state == RKBC_RUN && !pin_low)
        begin
            if (pin_fault_done)
                next_reset_cause_flags[rkbc_pkg::FLAG_PIN_KEY] = 1'b1;
            if (bo_qual_done)
                next_reset_cause_flags[rkbc_pkg::FLAG_BO] = 1'b1;
            if (bo_fault_done)
                next_reset_cause_flags[rkbc_pkg::FLAG_BO_KEY] = 1'b1;
            if (watchdog_key_fault)
                next_reset_cause_flags[rkbc_pkg::FLAG_WDT_KEY] = 1'b1;
        end
        next_reg_rdata = 8'h00;
        if (reg_read)
        begin
            case (reg_addr)
                rkbc_pkg::ADDR_PIN_KEY: next_reg_rdata = pin_function_key;
                rkbc_pkg::ADDR_FLAGS:   next_reg_rdata = {4'h0, reset_cause_flags};
                rkbc_pkg::ADDR_BO_KEY:  next_reg_rdata = brownout_threshold_key;
                rkbc_pkg::ADDR_STATUS:  next_reg_rdata = {2'h0, bo_enabled,
                                                          bo_sel, pin_is_reset,
                                                          system_reset};
                default:                next_reg_rdata = 8'h00;
            endcase
        end
        next_pin_is_reset   = (next_pin_function_key == rkbc_pkg::PIN_KEY_RESET);
        next_pin_alt_enable = pin_alt_select && !next_pin_is_reset;
        next_bo_en          = bo_enabled;
        next_bo_sel         = bo_sel;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_function_key       <= rkbc_pkg::PIN_KEY_RST;
            brownout_threshold_key <= rkbc_pkg::BO_KEY_RST;
            reset_cause_flags      <= 4'h0;
            state                  <= RKBC_RUN;
            pulse_count            <= 3'h0;
            system_reset           <= 1'b0;
            reg_rdata              <= 8'h00;
            pin_is_reset           <= 1'b0;
            pin_alt_enable         <= 1'b0;
            brownout_monitor_en    <= 1'b0;
            brownout_threshold_sel <= 3'h0;
        end
        else
        begin
            pin_function_key       <= next_pin_function_key;
            brownout_threshold_key <= next_brownout_threshold_key;
            reset_cause_flags      <= next_reset_cause_flags;
            state                  <= next_state;
            pulse_count            <= next_pulse_count;
            system_reset           <= next_system_reset;
            reg_rdata              <= next_reg_rdata;
            pin_is_reset           <= next_pin_is_reset;
            pin_alt_enable         <= next_pin_alt_enable;
            brownout_monitor_en    <= next_bo_en;
            brownout_threshold_sel <= next_bo_sel;
        end
    end
endmodule
`default_nettype wire

// ===== common/rkbc_pkg.sv
package rkbc_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] ADDR_PIN_KEY   = 2'h0;
    localparam logic [1:0] ADDR_FLAGS     = 2'h1;
    localparam logic [1:0] ADDR_BO_KEY    = 2'h2;
    localparam logic [1:0] ADDR_STATUS    = 2'h3;
    // Pin-function keys
    localparam logic [7:0] PIN_KEY_IO     = 8'h55;
    localparam logic [7:0] PIN_KEY_RESET  = 8'haa;
    localparam logic [7:0] PIN_KEY_RST    = 8'h55;
    // Brownout threshold codes
    localparam logic [7:0] BO_CODE_1V70   = 8'h66;
    localparam logic [7:0] BO_CODE_1V90   = 8'h55;
    localparam logic [7:0] BO_CODE_2V55   = 8'h33;
    localparam logic [7:0] BO_CODE_3V15   = 8'h99;
    localparam logic [7:0] BO_CODE_3V80   = 8'haa;
    localparam logic [7:0] BO_CODE_OFF    = 8'hf0;
    localparam logic [7:0] BO_KEY_RST     = 8'h66;
    // Flag bit positions
    localparam int FLAG_WDT_KEY = 0;
    localparam int FLAG_BO_KEY  = 1;
    localparam int FLAG_BO      = 2;
    localparam int FLAG_PIN_KEY = 3;
    // Timing
    localparam int CLK_HZ              = 50_000_000;
    localparam int SW_FAULT_DELAY_NS   = 100;
    localparam int PIN_RELEASE_US      = 16;
    localparam int BO_QUALIFY_US       = 120;
    localparam int SW_FAULT_CYCLES     =
        (SW_FAULT_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PIN_RELEASE_CYCLES  = PIN_RELEASE_US * (CLK_HZ / 1_000_000);
    localparam int BO_QUALIFY_CYCLES   = BO_QUALIFY_US * (CLK_HZ / 1_000_000);
    localparam int RESET_PULSE_CYCLES  = 4;
    localparam int CNT_W               = 16;
    // Threshold select encoding
    typedef enum logic [2:0]
    {
        BO_SEL_1V70,
        BO_SEL_1V90,
        BO_SEL_2V55,
        BO_SEL_3V15,
        BO_SEL_3V80,
        BO_SEL_OFF
    } rkbc_bo_sel_t;
endpackage

// ===== src/rkbc_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Counts while run is high; done is high once count reaches limit
module rkbc_delay
(
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    // Control
    input  wire logic                      run,
    input  wire logic [rkbc_pkg::CNT_W-1:0] limit,
    output logic                           done
);
    logic [rkbc_pkg::CNT_W-1:0] count;
    logic [rkbc_pkg::CNT_W-1:0] next_count;

    always_comb
    begin
        next_count = '0;
        if (run)
        begin
            next_count = (count == limit) ? count
                                          : rkbc_pkg::CNT_W'(count + 1'b1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            count <= '0;
        else
            count <= next_count;
    end

    assign done = run && (count == limit);
endmodule
`default_nettype wire

// ===== tb/rkbc_pin_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module rkbc_pin_supply_model
(
    // Scenario commands
    input  wire logic pull_low,
    input  wire logic sag,
    // Far-side levels
    output logic      pin_level,
    output logic      low_supply
);
    assign pin_level  = !pull_low;
    assign low_supply = sag;
endmodule
`default_nettype wire

// ===== tb/rkbc_reset_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rkbc_reset_ctrl_chk
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Watched ports
    input  wire logic [1:0] reg_addr,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       pin_level,
    input  wire logic       sleep_or_idle,
    input  wire logic       watchdog_key_fault,
    input  wire logic       pin_is_reset,
    input  wire logic       pin_alt_enable,
    input  wire logic       brownout_monitor_en,
    input  wire logic [2:0] brownout_threshold_sel,
    input  wire logic       system_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence pin_pull;
        $fell(pin_level) && pin_is_reset;
    endsequence
    sequence rst_pulse;
        system_reset [*4];
    endsequence
    flag_upper_a: assert property (
        reg_read && reg_addr == 2'h1 |=> reg_rdata[7:4] == 4'h0)
        else $error("flag upper bits not zero");
    alt_override_a: assert property (
        pin_is_reset |-> !pin_alt_enable)
        else $error("alternate use while pin is reset input");
    sleep_off_a: assert property (
        sleep_or_idle |=> !brownout_monitor_en)
        else $error("monitor on in sleep");
    sel_range_a: assert property (
        brownout_threshold_sel <= 3'h5)
        else $error("threshold select out of range");
    off_no_mon_a: assert property (
        brownout_monitor_en |-> brownout_threshold_sel != 3'h5)
        else $error("monitor on with disable code");
    pulse_len_a: assert property (
        $rose(system_reset) |-> rst_pulse)
        else $error("reset pulse too short");
    pin_pull_a: assert property (
        pin_pull |-> ##[1:2] system_reset)
        else $error("pin low did not reset");
    wdt_fault_a: assert property (
        watchdog_key_fault |-> ##[1:2] system_reset)
        else $error("watchdog key fault did not reset");
endmodule
`default_nettype wire

// ===== tb/reset_key_and_brownout_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reset_key_and_brownout_ctrl_tb_top;
    logic       ref_clk = 1'b0, reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic       reg_write = 1'b0, reg_read = 1'b0;
    logic       pin_alt_select = 1'b0, sleep_or_idle = 1'b0;
    logic       watchdog_key_fault = 1'b0, watchdog_warm_reset = 1'b0;
    logic       pull_low = 1'b0, sag = 1'b0, pin_level, low_supply;
    logic       pin_is_reset, pin_alt_enable, brownout_monitor_en;
    logic       system_reset;
    logic [2:0] brownout_threshold_sel;
    logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
    int         num_errors = 0, total_checks = 0, hi;
    rkbc_reset_ctrl uut (.ref_clk, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .pin_level, .pin_alt_select,
        .low_supply, .sleep_or_idle, .watchdog_key_fault,
        .watchdog_warm_reset, .pin_is_reset, .pin_alt_enable,
        .brownout_monitor_en, .brownout_threshold_sel, .system_reset);
    rkbc_pin_supply_model far (.pull_low, .sag, .pin_level, .low_supply);
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk("register read", exp, reg_rdata);
    endtask
    // Waits for one whole reset pulse, hi gets its length
    task automatic wait_rst();
        int n;
        n = 0;
        hi = 0;
        while (system_reset !== 1'b1 && n < 8000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        while (system_reset !== 1'b0 && n < 9000)
        begin
            @(posedge ref_clk);
            #1 n++;
            hi++;
        end
        if (n >= 9000 || hi == 0)
        begin
            num_errors++;
            $display("mismatch reset pulse expected seen none");
            print_verdict();
        end
        settle();
    endtask
    initial
    begin
        #1_800_000 num_errors++;
        $display("timeout");
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(rkbc_pkg::ADDR_PIN_KEY, 8'h55);
        rd(rkbc_pkg::ADDR_BO_KEY, 8'h66);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h00);
        rd(rkbc_pkg::ADDR_STATUS, 8'h20);
        pin_alt_select <= 1'b1;
        wr(rkbc_pkg::ADDR_PIN_KEY, 8'haa);
        settle();
        chk("pin role", 8'h01, {7'h0, pin_is_reset});
        chk("alt enable", 8'h00, {7'h0, pin_alt_enable});
        wr(rkbc_pkg::ADDR_PIN_KEY, 8'h55);
        settle();
        chk("alt enable", 8'h01, {7'h0, pin_alt_enable});
        for (int i = 0; i < 6; i++)
        begin
            wr(rkbc_pkg::ADDR_BO_KEY, codes[i]);
            settle();
            chk("select", i[7:0], {5'h0, brownout_threshold_sel});
            chk("monitor", {7'h0, i < 5}, {7'h0, brownout_monitor_en});
        end
        $display("threshold codes done");
        wr(rkbc_pkg::ADDR_BO_KEY, 8'h33);
        sleep_or_idle <= 1'b1;
        settle();
        chk("monitor", 8'h00, {7'h0, brownout_monitor_en});
        sleep_or_idle <= 1'b0;
        wr(rkbc_pkg::ADDR_STATUS, 8'hff);
        rd(rkbc_pkg::ADDR_PIN_KEY, 8'h55);
        wr(rkbc_pkg::ADDR_PIN_KEY, 8'h12);
        wait_rst();
        rd(rkbc_pkg::ADDR_FLAGS, 8'h08);
        rd(rkbc_pkg::ADDR_PIN_KEY, 8'h55);
        wr(rkbc_pkg::ADDR_FLAGS, 8'h00);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h00);
        wr(rkbc_pkg::ADDR_BO_KEY, 8'h12);
        wait_rst();
        rd(rkbc_pkg::ADDR_BO_KEY, 8'h66);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h02);
        wr(rkbc_pkg::ADDR_FLAGS, 8'h00);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h00);
        $display("key faults done");
        wr(rkbc_pkg::ADDR_BO_KEY, 8'h33);
        sag <= 1'b1;
        repeat (100) @(posedge ref_clk);
        sag <= 1'b0;
        settle();
        chk("short sag reset", 8'h00, {7'h0, system_reset});
        sag <= 1'b1;
        wait_rst();
        sag <= 1'b0;
        rd(rkbc_pkg::ADDR_FLAGS, 8'h04);
        rd(rkbc_pkg::ADDR_BO_KEY, 8'h33);
        wr(rkbc_pkg::ADDR_FLAGS, 8'h04);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h04);
        wr(rkbc_pkg::ADDR_FLAGS, 8'h00);
        rd(rkbc_pkg::ADDR_FLAGS, 8'h00);
        $display("brownout done");
        @(posedge ref_clk);
        watchdog_key_fault <= 1'b1;
        @(posedge ref_clk);
        watchdog_key_fault <= 1'b0;
        wait_rst();
        rd(rkbc_pkg::ADDR_FLAGS, 8'h01);
        wr(rkbc_pkg::ADDR_FLAGS, 8'h00);
        wr(rkbc_pkg::ADDR_PIN_KEY, 8'haa);
        @(posedge ref_clk);
        watchdog_warm_reset <= 1'b1;
        @(posedge ref_clk);
        watchdog_warm_reset <= 1'b0;
        wait_rst();
        rd(rkbc_pkg::ADDR_PIN_KEY, 8'haa);
        pull_low <= 1'b1;
        fork
            begin
                repeat (10) @(posedge ref_clk);
                pull_low <= 1'b0;
            end
        join_none
        wait_rst();
        chk("release wait", 8'h01,
            {7'h0, hi >= rkbc_pkg::PIN_RELEASE_CYCLES + 8});
        rd(rkbc_pkg::ADDR_PIN_KEY, 8'h55);
        $display("pin and watchdog done");
        print_verdict();
    end
endmodule
bind rkbc_reset_ctrl rkbc_reset_ctrl_chk chk_i (.ref_clk, .reset,
    .reg_addr, .reg_read, .reg_rdata, .pin_level, .sleep_or_idle,
    .watchdog_key_fault, .pin_is_reset, .pin_alt_enable,
    .brownout_monitor_en, .brownout_threshold_sel, .system_reset);
`default_nettype wire
